// *** rtl/dcpwm_cfg.svh ***
`ifndef DCPWM_CFG_SVH
`define DCPWM_CFG_SVH
// global register byte offsets
`define DCPWM_START_OFS 8'h00
`define DCPWM_MODE_OFS 8'h04
`define DCPWM_FUNC_OFS 8'h08
`define DCPWM_OUTEN_OFS 8'h0C
`define DCPWM_OUTLVL_OFS 8'h10
`define DCPWM_POL_OFS 8'h14
`define DCPWM_PINCFG_OFS 8'h18
// channel windows and offsets inside one window
`define DCPWM_CH0_BASE 3'h1
`define DCPWM_CH1_BASE 3'h2
`define DCPWM_CTRL_OFS 5'h00
`define DCPWM_STAT_OFS 5'h04
`define DCPWM_CNT_OFS 5'h08
`define DCPWM_GRA_OFS 5'h0C
`define DCPWM_GRB_OFS 5'h10
`define DCPWM_GRC_OFS 5'h14
`define DCPWM_GRD_OFS 5'h18
`define DCPWM_AUX_OFS 5'h1C
// channel register selects
`define DCPWM_SEL_CNT 3'h0
`define DCPWM_SEL_GRA 3'h1
`define DCPWM_SEL_GRB 3'h2
`define DCPWM_SEL_GRC 3'h3
`define DCPWM_SEL_GRD 3'h4
// status and pin configuration bit positions
`define DCPWM_ST_OVF 4
`define DCPWM_ST_UNUSED 5
`define DCPWM_PC_LEVEL 2
`define DCPWM_PC_FLAG 3
// reset values, counter maximum, source and pin function codes
`define DCPWM_GR_RST 16'hFFFF
`define DCPWM_CNT_MAX 16'hFFFF
`define DCPWM_SRC_EXT 3'h5
`define DCPWM_FN_GPIO 2'h0
`define DCPWM_FN_CUTOFF 2'h1
`define DCPWM_FN_INT 2'h2
`endif

// *** rtl/dcpwm_pkg.sv ***
package dcpwm_pkg;
  // count source code, edge code, pin function code
  typedef logic [2:0] dcpwm_src_t;
  typedef logic [1:0] dcpwm_edge_t;
  typedef logic [1:0] dcpwm_fn_t;
  typedef logic [15:0] dcpwm_cnt_t;
endpackage

// *** rtl/dcpwm_source.sv ***
`timescale 1ns/1ps
`include "dcpwm_cfg.svh"
// picks one count tick per channel from prescaler taps or external pin
module dcpwm_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] taps, // f1,f2,f4,f8,f32 enables
  input wire logic ext_rise,
  input wire logic ext_fall,
  input wire logic ext_en,
  input wire dcpwm_pkg::dcpwm_src_t sel,
  input wire dcpwm_pkg::dcpwm_edge_t edge_sel,
  output logic tick
);
  // tap or qualified external edge
  always_comb begin
    tick = 1'b0;
    if (sel < `DCPWM_SRC_EXT) begin
      tick = taps[sel];
    end else if (sel == `DCPWM_SRC_EXT && ext_en) begin
      case (edge_sel)
        2'h0: tick = ext_rise;
        2'h1: tick = ext_fall;
        default: tick = ext_rise | ext_fall;
      endcase
    end
  end

  a_ext_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (sel == `DCPWM_SRC_EXT && !ext_en) |-> !tick)
    else $error("external tick without enable");
endmodule // dcpwm_source

// *** rtl/dcpwm_channel.sv ***
`timescale 1ns/1ps
`include "dcpwm_cfg.svh"
// one channel: counter, period and change-point registers, three pins
module dcpwm_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic run,
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wdata,
  input wire logic bfc,
  input wire logic bfd,
  input wire logic lvl_load,
  input wire logic [2:0] init_lvl,
  input wire logic [2:0] pol,
  output dcpwm_pkg::dcpwm_cnt_t cnt,
  output dcpwm_pkg::dcpwm_cnt_t gra,
  output dcpwm_pkg::dcpwm_cnt_t grb,
  output dcpwm_pkg::dcpwm_cnt_t grc,
  output dcpwm_pkg::dcpwm_cnt_t grd,
  output logic [3:0] match,
  output logic ovf,
  output logic [2:0] pin
);
  dcpwm_pkg::dcpwm_cnt_t cnt_d, gra_d, grb_d, grc_d, grd_d; // next values
  logic [2:0] pin_d; // next pin levels (b,c,d)

  // counting, compares, buffer transfer, then bus writes
  always_comb begin
    cnt_d = cnt;
    gra_d = gra;
    grb_d = grb;
    grc_d = grc;
    grd_d = grd;
    pin_d = pin;
    match = 4'h0;
    ovf = 1'b0;
    if (tick && run) begin
      match[1] = (cnt == grb);
      match[2] = (cnt == grc);
      match[3] = (cnt == grd);
      if (match[1]) pin_d[0] = pol[0];
      if (match[2] && !bfc) pin_d[1] = pol[1];
      if (match[3] && !bfd) pin_d[2] = pol[2];
      if (cnt == gra) begin
        match[0] = 1'b1;
        cnt_d = 16'h0000;
        pin_d = ~pol;
        if (bfc) gra_d = grc;
        if (bfd) grb_d = grd;
      end else begin
        cnt_d = cnt + 16'h0001;
        ovf = (cnt == `DCPWM_CNT_MAX);
      end
    end
    if (wr_en) begin
      case (wr_sel)
        `DCPWM_SEL_CNT: cnt_d = wdata;
        `DCPWM_SEL_GRA: gra_d = wdata;
        `DCPWM_SEL_GRB: grb_d = wdata;
        `DCPWM_SEL_GRC: grc_d = wdata;
        default: grd_d = wdata;
      endcase
    end
    if (lvl_load) pin_d = init_lvl;
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      gra <= `DCPWM_GR_RST;
      grb <= `DCPWM_GR_RST;
      grc <= `DCPWM_GR_RST;
      grd <= `DCPWM_GR_RST;
      pin <= 3'h0;
    end else begin
      cnt <= cnt_d;
      gra <= gra_d;
      grb <= grb_d;
      grc <= grc_d;
      grd <= grd_d;
      pin <= pin_d;
    end
  end

  a_period_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && run && !wr_en && cnt == gra) |=> (cnt == 16'h0000 && pin == ~$past(pol)))
    else $error("period match did not clear counter");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && run && !wr_en && cnt != gra) |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not advance");
  a_buf_period: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && run && bfc && cnt == gra && !wr_en) |=> gra == $past(grc))
    else $error("period buffer not transferred");
  a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
    lvl_load |=> pin == $past(init_lvl))
    else $error("initial level not driven");
endmodule // dcpwm_channel

// *** rtl/dcpwm_top.sv ***
`timescale 1ns/1ps
`include "dcpwm_cfg.svh"
// Notes on behaviour
// - one to three pins per channel enabled
// - active level chosen per pin
// - initial level chosen per pin
// - counter readable and writable by software
// - interrupt pin is gpio, cutoff or interrupt
// - period match clears start when select clear
// - level register write drives initial level
// - edge select needs external clock enable
// - edge bits act only for external source
// - flag clears on zero write after one read
// - status bit five unused, written zero
// - C and D flags set even when buffering
// - filter and io control registers inert
// - register A sets the period
// - B, C, D registers set change points
// - buffered C feeds A at period match
// - buffered D feeds B at period match
// - counter steps on selected source edge
module dcpwm_top #(
  parameter int PRE_W = 5 // prescaler width, f32 needs five bits
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_pin, // external count clock pin
  input wire logic ext_int_pin, // gpio, cutoff or interrupt pin
  output logic [5:0] pwm_pin_o, // b0,c0,d0,b1,c1,d1
  output logic [5:0] pwm_pin_oe_n // low while the pin is driven
);
  // control registers
  logic [1:0] start_q, start_d; // count start per channel
  logic [1:0] stop_sel_q, stop_sel_d; // 1: software stop, 0: stop at period match
  logic [3:0] buf_q, buf_d; // {bfd1,bfc1,bfd0,bfc0}
  logic ext_en_q, ext_en_d; // external clock input enable
  logic [5:0] outen_q, outen_d; // waveform output per pin
  logic [5:0] init_q, init_d; // initial level per pin
  logic [5:0] pol_q, pol_d; // active level per pin
  dcpwm_pkg::dcpwm_fn_t fn_q, fn_d; // interrupt pin function
  logic int_flag_q, int_flag_d; // interrupt pin edge seen
  logic [4:0] ctrl_q [2], ctrl_d [2]; // {edge[1:0], source[2:0]}
  logic [7:0] aux_q [2], aux_d [2]; // filter and io control, no effect
  logic [4:0] stat_q [2], stat_d [2]; // ovf,imfd,imfc,imfb,imfa
  logic [4:0] armed_q [2], armed_d [2]; // flags read back as 1
  // bus answer and pins
  logic pready_d;
  logic [31:0] prdata_d;
  logic pslverr_d;
  logic [5:0] pin_d, oe_n_d;
  logic lvl_load; // output level register written this cycle
  // synchronisers and prescaler
  logic [2:0] ext_s_q; // external clock: two sync stages plus history
  logic [2:0] int_s_q; // interrupt pin: two sync stages plus history
  logic [PRE_W-1:0] pre_q;
  logic [4:0] taps;
  // channel wiring
  logic [1:0] tick;
  logic [1:0] ch_wr;
  logic [2:0] ch_sel;
  dcpwm_pkg::dcpwm_cnt_t cnt [2], gra [2], grb [2], grc [2], grd [2];
  logic [3:0] match [2];
  logic [1:0] ovf;
  logic [2:0] ch_pin [2];
  logic access, wr, rd; // completing access phase
  logic [7:0] ofs;
  logic [31:0] rdv;
  logic hit;

  // channel window for an address, 0 when global space
  function automatic logic [2:0] win_of(input logic [7:0] a);
    return a[7:5];
  endfunction

  // channel register select from offset inside its window
  function automatic logic [2:0] sel_of(input logic [4:0] o);
    return 3'(o[4:2] - 3'h2);
  endfunction

  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign ofs = paddr[7:0];
  assign ch_sel = sel_of(ofs[4:0]);
  assign taps = {&pre_q[4:0], &pre_q[2:0], &pre_q[1:0], pre_q[0], 1'b1};

  // read mux and address decode
  always_comb begin
    rdv = 32'h0000_0000;
    hit = (paddr[11:8] == 4'h0);
    ch_wr = 2'h0;
    if (ofs == `DCPWM_START_OFS) begin
      rdv[3:0] = {stop_sel_q, start_q};
    end else if (ofs == `DCPWM_MODE_OFS) begin
      rdv[3:0] = buf_q;
    end else if (ofs == `DCPWM_FUNC_OFS) begin
      rdv[0] = ext_en_q;
    end else if (ofs == `DCPWM_OUTEN_OFS) begin
      rdv[5:0] = outen_q;
    end else if (ofs == `DCPWM_OUTLVL_OFS) begin
      rdv[5:0] = init_q;
    end else if (ofs == `DCPWM_POL_OFS) begin
      rdv[5:0] = pol_q;
    end else if (ofs == `DCPWM_PINCFG_OFS) begin
      rdv[3:0] = {int_flag_q, int_s_q[1], fn_q};
    end else if (win_of(ofs) == `DCPWM_CH0_BASE || win_of(ofs) == `DCPWM_CH1_BASE) begin
      for (int c = 0; c < 2; c++) begin
        if (win_of(ofs) == 3'(c + 1)) begin
          if (ofs[4:0] == `DCPWM_CTRL_OFS) rdv[4:0] = ctrl_q[c];
          else if (ofs[4:0] == `DCPWM_STAT_OFS) rdv[4:0] = stat_q[c];
          else if (ofs[4:0] == `DCPWM_CNT_OFS) rdv[15:0] = cnt[c];
          else if (ofs[4:0] == `DCPWM_GRA_OFS) rdv[15:0] = gra[c];
          else if (ofs[4:0] == `DCPWM_GRB_OFS) rdv[15:0] = grb[c];
          else if (ofs[4:0] == `DCPWM_GRC_OFS) rdv[15:0] = grc[c];
          else if (ofs[4:0] == `DCPWM_GRD_OFS) rdv[15:0] = grd[c];
          else rdv[7:0] = aux_q[c];
          ch_wr[c] = wr && hit && ofs[4:0] >= `DCPWM_CNT_OFS && ofs[4:0] <= `DCPWM_GRD_OFS;
        end
      end
    end else begin
      hit = 1'b0; // unmapped offset
    end
  end

  // next state for control, flags, bus answer and pins
  always_comb begin
    start_d = start_q;
    stop_sel_d = stop_sel_q;
    buf_d = buf_q;
    ext_en_d = ext_en_q;
    outen_d = outen_q;
    init_d = init_q;
    pol_d = pol_q;
    fn_d = fn_q;
    int_flag_d = int_flag_q;
    ctrl_d = ctrl_q;
    aux_d = aux_q;
    stat_d = stat_q;
    armed_d = armed_q;
    lvl_load = 1'b0;
    // one wait state, then answer from flip-flops
    pready_d = psel && penable && !pready;
    prdata_d = pready_d && !pwrite && hit ? rdv : 32'h0000_0000; // unmapped reads 0
    pslverr_d = pready_d && !hit;
    if (wr && hit) begin
      if (ofs == `DCPWM_START_OFS) begin
        start_d = pwdata[1:0];
        stop_sel_d = pwdata[3:2];
      end else if (ofs == `DCPWM_MODE_OFS) begin
        buf_d = pwdata[3:0];
      end else if (ofs == `DCPWM_FUNC_OFS) begin
        ext_en_d = pwdata[0];
      end else if (ofs == `DCPWM_OUTEN_OFS) begin
        outen_d = pwdata[5:0];
      end else if (ofs == `DCPWM_OUTLVL_OFS) begin
        init_d = pwdata[5:0];
        lvl_load = 1'b1;
      end else if (ofs == `DCPWM_POL_OFS) begin
        pol_d = pwdata[5:0];
      end else if (ofs == `DCPWM_PINCFG_OFS) begin
        fn_d = pwdata[1:0];
        if (!pwdata[`DCPWM_PC_FLAG]) int_flag_d = 1'b0;
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (hit && access && win_of(ofs) == 3'(c + 1)) begin
        if (ofs[4:0] == `DCPWM_CTRL_OFS && pwrite) ctrl_d[c] = pwdata[4:0];
        if (ofs[4:0] == `DCPWM_AUX_OFS && pwrite) aux_d[c] = pwdata[7:0];
        if (ofs[4:0] == `DCPWM_STAT_OFS) begin
          if (pwrite) begin
            stat_d[c] = stat_q[c] & ~(armed_q[c] & ~pwdata[4:0]);
            armed_d[c] = 5'h00;
          end else if (rd) begin
            armed_d[c] = stat_q[c];
          end
        end
      end
      stat_d[c] = stat_d[c] | {ovf[c], match[c]};
      if (match[c][0] && !stop_sel_q[c]) start_d[c] = 1'b0;
    end
    if (fn_q == `DCPWM_FN_INT && int_s_q[2] && !int_s_q[1]) int_flag_d = 1'b1;
    // cutoff forces inactive level while the pin is low
    for (int i = 0; i < 6; i++) begin
      pin_d[i] = ch_pin[i / 3][i % 3];
      if (fn_q == `DCPWM_FN_CUTOFF && !int_s_q[1]) pin_d[i] = ~pol_q[i];
      oe_n_d[i] = !outen_q[i];
    end
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 2'h0;
      stop_sel_q <= 2'h0;
      buf_q <= 4'h0;
      ext_en_q <= 1'b0;
      outen_q <= 6'h00;
      init_q <= 6'h00;
      pol_q <= 6'h00;
      fn_q <= `DCPWM_FN_GPIO;
      int_flag_q <= 1'b0;
      ctrl_q <= '{default: 5'h00};
      aux_q <= '{default: 8'h00};
      stat_q <= '{default: 5'h00};
      armed_q <= '{default: 5'h00};
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pwm_pin_o <= 6'h00;
      pwm_pin_oe_n <= 6'h3F;
      ext_s_q <= 3'h0;
      int_s_q <= 3'h7;
      pre_q <= '0;
    end else begin
      start_q <= start_d;
      stop_sel_q <= stop_sel_d;
      buf_q <= buf_d;
      ext_en_q <= ext_en_d;
      outen_q <= outen_d;
      init_q <= init_d;
      pol_q <= pol_d;
      fn_q <= fn_d;
      int_flag_q <= int_flag_d;
      ctrl_q <= ctrl_d;
      aux_q <= aux_d;
      stat_q <= stat_d;
      armed_q <= armed_d;
      pready <= pready_d;
      prdata <= prdata_d;
      pslverr <= pslverr_d;
      pwm_pin_o <= pin_d;
      pwm_pin_oe_n <= oe_n_d;
      ext_s_q <= {ext_s_q[1:0], ext_clk_pin};
      int_s_q <= {int_s_q[1:0], ext_int_pin};
      pre_q <= pre_q + 1'b1;
    end
  end

  // per-channel source select and waveform engine
  for (genvar c = 0; c < 2; c++) begin : g_ch
    dcpwm_source u_src (
      .pclk(pclk),
      .presetn(presetn),
      .taps(taps),
      .ext_rise(ext_s_q[1] && !ext_s_q[2]),
      .ext_fall(!ext_s_q[1] && ext_s_q[2]),
      .ext_en(ext_en_q),
      .sel(ctrl_q[c][2:0]),
      .edge_sel(ctrl_q[c][4:3]),
      .tick(tick[c])
    );
    dcpwm_channel u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick[c]),
      .run(start_q[c]),
      .wr_en(ch_wr[c]),
      .wr_sel(ch_sel),
      .wdata(pwdata[15:0]),
      .bfc(buf_q[2 * c]),
      .bfd(buf_q[2 * c + 1]),
      .lvl_load(lvl_load),
      .init_lvl(init_d[3 * c +: 3]),
      .pol(pol_q[3 * c +: 3]),
      .cnt(cnt[c]),
      .gra(gra[c]),
      .grb(grb[c]),
      .grc(grc[c]),
      .grd(grd[c]),
      .match(match[c]),
      .ovf(ovf[c]),
      .pin(ch_pin[c])
    );
  end

  a_stop_match: assert property (@(posedge pclk) disable iff (!presetn)
    (match[0][0] && !stop_sel_q[0] && !wr) |=> !start_q[0])
    else $error("channel 0 kept counting after period match");
  a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ovf[1] |=> stat_q[1][`DCPWM_ST_OVF])
    else $error("overflow flag not set");
  a_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && ofs == {`DCPWM_CH0_BASE, `DCPWM_STAT_OFS} && pwdata[0] && stat_q[0][0])
      |=> stat_q[0][0])
    else $error("writing 1 cleared a flag");
  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) && !pwrite && ofs[4:0] == `DCPWM_STAT_OFS && win_of(ofs) != 3'h0
      |-> prdata[`DCPWM_ST_UNUSED] == 1'b0)
    else $error("unused status bit read as one");
  a_pin_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (fn_q == `DCPWM_FN_GPIO && outen_q[0]) ##1 (fn_q == `DCPWM_FN_GPIO)
      |-> pwm_pin_o[0] == $past(ch_pin[0][0]) && !pwm_pin_oe_n[0])
    else $error("enabled pin not driven by channel");
endmodule // dcpwm_top

// *** test/dcpwm_load.sv ***
`timescale 1ns/1ps
// loads on the six pwm pins, pulled down while a pin is not driven
module dcpwm_load (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] pin_o, // pin levels from the timer
  input wire logic [5:0] oe_n, // low while the timer drives a pin
  input wire logic meas, // measurement window
  output logic [5:0] lvl, // level the loads really see
  output logic [7:0] hi_cnt_q [6] // high cycles per pin in the window
);
  logic meas_q; // window start detect
  // an undriven pin falls to the pull-down level
  assign lvl = pin_o & ~oe_n;
  // count high cycles per pin, restart at each new window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_q <= 1'b0;
      hi_cnt_q <= '{default: '0};
    end else begin
      meas_q <= meas;
      for (int i = 0; i < 6; i++) begin
        if (meas && !meas_q) begin
          hi_cnt_q[i] <= {7'h0, lvl[i]};
        end else if (meas) begin
          hi_cnt_q[i] <= hi_cnt_q[i] + {7'h0, lvl[i]};
        end
      end
    end
  end
endmodule // dcpwm_load

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "dcpwm_cfg.svh"
// self-checking bench, software side over apb, loads on the pins
module tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_clk_pin;
  logic ext_int_pin;
  logic [5:0] pwm_pin_o;
  logic [5:0] pwm_pin_oe_n;
  logic [5:0] lvl; // level seen by the loads
  logic meas; // load measurement window
  logic [7:0] hi_cnt [6]; // high cycles per pin
  logic [31:0] rd; // last read data
  logic err; // last slave error
  int errors;
  int total_checks;
  // global register addresses
  localparam logic [11:0] R_ST = {4'h0, `DCPWM_START_OFS};
  localparam logic [11:0] R_MD = {4'h0, `DCPWM_MODE_OFS};
  localparam logic [11:0] R_FN = {4'h0, `DCPWM_FUNC_OFS};
  localparam logic [11:0] R_OE = {4'h0, `DCPWM_OUTEN_OFS};
  localparam logic [11:0] R_IL = {4'h0, `DCPWM_OUTLVL_OFS};
  localparam logic [11:0] R_PL = {4'h0, `DCPWM_POL_OFS};
  localparam logic [11:0] R_PC = {4'h0, `DCPWM_PINCFG_OFS};
  // expected high cycles per 100: b0,c0,d0,b1,c1,d1
  localparam logic [7:0] HI_EXP [6] = '{8'h28, 8'h28, 8'h14, 8'h3C, 8'h00, 8'h00};

  dcpwm_top dcpwm_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
    .ext_int_pin(ext_int_pin), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_n(pwm_pin_oe_n)
  );
  dcpwm_load dcpwm_load_i (
    .pclk(pclk), .presetn(presetn), .pin_o(pwm_pin_o), .oe_n(pwm_pin_oe_n),
    .meas(meas), .lvl(lvl), .hi_cnt_q(hi_cnt)
  );

  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // channel register address
  function automatic logic [11:0] ca(input logic c, input logic [4:0] o);
    ca = {4'h0, c ? `DCPWM_CH1_BASE : `DCPWM_CH0_BASE, o};
  endfunction

  // one apb transfer, held until pready is sampled high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so psel is never assigned twice in one time step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // compare and count
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, rd);
  endtask

  // open a 100 cycle window on the loads
  task automatic measure();
    meas <= 1'b1;
    repeat (100) @(posedge pclk);
    meas <= 1'b0;
    @(posedge pclk);
  endtask

  // slow rising and falling edges on the external clock pin
  task automatic tog(input int n);
    repeat (n) begin
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // cut a hung run short
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    results();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_clk_pin = 1'b0;
    ext_int_pin = 1'b1;
    meas = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and an unmapped address
    chk("gra0", ca(0, `DCPWM_GRA_OFS), 32'h0000FFFF);
    chk("cnt0", ca(0, `DCPWM_CNT_OFS), 32'h0);
    cmp("oe_n", 32'h3F, {26'h0, pwm_pin_oe_n});
    bus(1'b0, 12'h12C, 32'h0);
    cmp("slverr", 32'h1, {31'h0, err});
    cmp("unmapped", 32'h0, rd);
    wr(ca(0, `DCPWM_CNT_OFS), 32'h1234);
    chk("cnt0", ca(0, `DCPWM_CNT_OFS), 32'h1234);
    $display("test reset and counter access done");
    // initial levels while stopped
    wr(R_OE, 32'h3F);
    wr(R_PL, 32'h2E);
    wr(R_IL, 32'h2A);
    repeat (3) @(posedge pclk);
    cmp("init", 32'h2A, {26'h0, lvl});
    wr(R_IL, 32'h15);
    repeat (3) @(posedge pclk);
    cmp("init", 32'h15, {26'h0, lvl});
    $display("test initial levels done");
    // duty of every pin, four pins driven, one active low
    wr(ca(0, `DCPWM_GRA_OFS), 32'h9);
    wr(ca(0, `DCPWM_GRB_OFS), 32'h3);
    wr(ca(0, `DCPWM_GRC_OFS), 32'h5);
    wr(ca(0, `DCPWM_GRD_OFS), 32'h7);
    wr(ca(0, `DCPWM_CNT_OFS), 32'h0);
    wr(ca(0, `DCPWM_AUX_OFS), 32'hFF);
    wr(ca(1, `DCPWM_GRA_OFS), 32'h4);
    wr(ca(1, `DCPWM_GRB_OFS), 32'h1);
    wr(ca(1, `DCPWM_CTRL_OFS), 32'h1);
    wr(R_OE, 32'h0F);
    wr(R_ST, 32'hF);
    repeat (20) @(posedge pclk);
    measure();
    for (int i = 0; i < 6; i++) begin
      cmp($sformatf("high%0d", i), {24'h0, HI_EXP[i]}, {24'h0, hi_cnt[i]});
    end
    cmp("oe_n", 32'h30, {26'h0, pwm_pin_oe_n});
    wr(R_ST, 32'hC);
    $display("test pwm duty done");
    // flag clearing needs a read of one first
    wr(ca(0, `DCPWM_STAT_OFS), 32'h0);
    chk("st0", ca(0, `DCPWM_STAT_OFS), 32'h0F);
    wr(ca(0, `DCPWM_STAT_OFS), 32'h0F);
    wr(ca(0, `DCPWM_STAT_OFS), 32'h0);
    chk("st0", ca(0, `DCPWM_STAT_OFS), 32'h0F);
    wr(ca(0, `DCPWM_STAT_OFS), 32'h0);
    chk("st0", ca(0, `DCPWM_STAT_OFS), 32'h0);
    $display("test status flags done");
    // wrap through zero, then stop at the period match
    wr(ca(0, `DCPWM_CNT_OFS), 32'hFFFE);
    wr(R_ST, 32'h1);
    repeat (30) @(posedge pclk);
    chk("start", R_ST, 32'h0);
    chk("cnt0", ca(0, `DCPWM_CNT_OFS), 32'h0);
    chk("st0", ca(0, `DCPWM_STAT_OFS), 32'h1F);
    wr(ca(0, `DCPWM_STAT_OFS), 32'h0);
    $display("test match stop done");
    // buffered c and d feed a and b
    wr(ca(0, `DCPWM_GRC_OFS), 32'h13);
    wr(ca(0, `DCPWM_GRD_OFS), 32'h5);
    wr(R_MD, 32'h3);
    wr(R_ST, 32'h5);
    repeat (50) @(posedge pclk);
    wr(R_ST, 32'h4);
    chk("gra0", ca(0, `DCPWM_GRA_OFS), 32'h13);
    chk("grb0", ca(0, `DCPWM_GRB_OFS), 32'h5);
    chk("st0", ca(0, `DCPWM_STAT_OFS), 32'h0F);
    $display("test buffer done");
    // external clock pin with edge choice and enable
    wr(ca(1, `DCPWM_GRA_OFS), 32'hFFFF);
    wr(ca(1, `DCPWM_CNT_OFS), 32'h0);
    wr(ca(1, `DCPWM_CTRL_OFS), 32'h05);
    wr(R_FN, 32'h1);
    wr(R_ST, 32'hE);
    tog(3);
    chk("cnt1", ca(1, `DCPWM_CNT_OFS), 32'h3);
    wr(ca(1, `DCPWM_CTRL_OFS), 32'h15);
    tog(3);
    chk("cnt1", ca(1, `DCPWM_CNT_OFS), 32'h9);
    wr(R_FN, 32'h0);
    tog(3);
    chk("cnt1", ca(1, `DCPWM_CNT_OFS), 32'h9);
    wr(R_ST, 32'hC);
    $display("test external clock done");
    // interrupt pin as port, interrupt input and cutoff input
    chk("pcfg", R_PC, 32'h04);
    wr(R_PC, 32'h2);
    ext_int_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("pcfg", R_PC, 32'h0A);
    wr(R_PC, 32'h2);
    chk("pcfg", R_PC, 32'h02);
    wr(R_OE, 32'h3F);
    wr(R_PC, 32'h1);
    repeat (4) @(posedge pclk);
    cmp("cutoff", 32'h11, {26'h0, lvl});
    ext_int_pin <= 1'b1;
    $display("test pin functions done");
    results();
  end
endmodule // tb
